// file: pkg/tss_pkg.sv
// constants and carriers for the two-wire serial slave block
// assumes byte-wide registers on a 32-bit classic wishbone slave
package tss_pkg;
    localparam logic [4:0] ADR_MODE = 5'h00;
    localparam logic [4:0] ADR_STAT = 5'h04;
    localparam logic [4:0] ADR_SADR = 5'h08;
    localparam logic [4:0] ADR_DATA = 5'h0c;
    localparam logic [4:0] ADR_TOUT = 5'h10;
    localparam logic [4:0] ADR_IRQS = 5'h14;
    localparam logic [4:0] ADR_IRQM = 5'h18;
    localparam logic [2:0] MODE_TWI = 3'h6;
    localparam logic [2:0] MODE_OFF = 3'h7;
    localparam logic [7:0] MODE_RST = 8'he0;
    localparam logic [7:0] STAT_RST = 8'h81;
    localparam logic [1:0] DEB_NONE = 2'h0;
    localparam logic [1:0] DEB_TWO = 2'h1;
    localparam logic [2:0] DEB_CNT2 = 3'h2;
    localparam logic [2:0] DEB_CNT4 = 3'h4;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_MATCH = 1;
    localparam int IRQ_STOP = 2;
    localparam logic [2:0] IRQ_MASK_W = 3'h7;

    typedef struct packed {
        logic [2:0] mode_select;
        logic [1:0] debounce_select;
        logic interface_enable;
        logic spi_incomplete_flag;
    } tss_mode_t;

    typedef struct packed {
        logic transfer_done_flag;
        logic address_match_flag;
        logic bus_busy_flag;
        logic transmit_select;
        logic ack_to_send;
        logic master_read_flag;
        logic match_wakeup_enable;
        logic ack_received_flag;
    } tss_stat_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_ACK = 5'b00100,
        ST_DATA = 5'b01000,
        ST_SKIP = 5'b10000
    } tss_state_t;
endpackage

// file: tb/tss_bus_master.sv
// two-wire bus master model that drives the shared clock and data wires
// assumes both wires are pulled up outside; every party only pulls low
`timescale 1ns/1ps
module tss_bus_master (
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    localparam int QTR = 80;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // one clock of 320 ns, data set while the clock is low
    task automatic bit_cyc(input logic b, output logic seen);
        sda_low = ~b;
        #QTR;
        scl_low = 1'b0;
        #QTR;
        seen = sda;
        #QTR;
        scl_low = 1'b1;
        #QTR;
    endtask
    // odd offset keeps the link edges off the system clock edges
    task automatic start_cond();
        #13;
        sda_low = 1'b1;
        #QTR;
        scl_low = 1'b1;
        #QTR;
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        #QTR;
        scl_low = 1'b0;
        #QTR;
        sda_low = 1'b0;
        #(2 * QTR);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, ack);
    endtask
    task automatic recv(input logic nak, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, d[i]);
        end
        bit_cyc(nak, s);
    endtask
endmodule

// file: tb/tss_slave_tb.sv
// self-checking bench for the two-wire serial slave
// assumes the bus master model of tss_bus_master.sv on the wires
`timescale 1ns/1ps
module tss_slave_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] wb_adr = 5'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [3:0] wb_sel = 4'hf;
    logic wb_we = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic bad = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, scl_o, scl_oe, sda_o, sda_oe, irq, scl_low, sda_low, ack;
    logic [7:0] rd, dat, sadr, got;
    int n_errors = 0;
    int cmp_count = 0;
    wire scl = ~(scl_low | (scl_oe & ~scl_o));
    wire sda = ~(sda_low | (sda_oe & ~sda_o));
    initial begin
        forever #20 clock = ~clock;
    end
    tss_slave u_tss_slave (.clock(clock), .rst_b(rst_b), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .irq(irq));
    tss_bus_master u_tss_bus_master (.sda(sda), .scl_low(scl_low), .sda_low(sda_low));
    // the device may only pull the data line low and never the clock
    always @(posedge clock) begin
        if (rst_b && (scl_oe !== 1'b0 || sda_o !== 1'b0)) bad <= 1'b1;
    end
    function automatic logic [7:0] en_stat(input logic [7:0] p);
        return {3'h4, p[4:3], 3'h1};
    endfunction
    task automatic stop_test();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= {24'h0, d};
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do begin
            @(posedge clock);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        wb(1'b0, a, 8'h00);
        chk(rd & m, e);
    endtask
    initial begin
        #400000;
        n_errors++;
        stop_test();
    end
    initial begin
        dat = 8'($urandom(3));
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rchk(tss_pkg::ADR_MODE, tss_pkg::MODE_RST, 8'hff);
        rchk(tss_pkg::ADR_STAT, tss_pkg::STAT_RST, 8'hff);
        rchk(5'h1c, 8'h00, 8'hff);
        for (int m = 0; m < 32; m++) begin
            dat = {m[4:2], 1'b1, m[1:0], 2'h0};
            wb(1'b1, tss_pkg::ADR_MODE, dat);
            rchk(tss_pkg::ADR_MODE, dat & 8'hef, 8'hff);
        end
        sadr = 8'($urandom);
        wb(1'b1, tss_pkg::ADR_SADR, sadr);
        rchk(tss_pkg::ADR_SADR, sadr, 8'hff);
        wb(1'b1, tss_pkg::ADR_IRQM, 8'h07);
        wb(1'b1, tss_pkg::ADR_STAT, 8'h18);
        wb(1'b1, tss_pkg::ADR_MODE, 8'hc2);
        rchk(tss_pkg::ADR_STAT, en_stat(8'h18), 8'hff);
        wb(1'b1, tss_pkg::ADR_STAT, 8'h00);
        dat = 8'($urandom);
        u_tss_bus_master.start_cond();
        u_tss_bus_master.send({sadr[7:1], 1'b0}, ack);
        chk({7'h0, ack}, 8'h00);
        rchk(tss_pkg::ADR_STAT, 8'h60, 8'h64);
        u_tss_bus_master.send(dat, ack);
        chk({7'h0, ack}, 8'h00);
        rchk(tss_pkg::ADR_STAT, 8'h80, 8'h80);
        rchk(tss_pkg::ADR_IRQS, 8'h03, 8'h03);
        chk({7'h0, irq}, 8'h01);
        rchk(tss_pkg::ADR_DATA, dat, 8'hff);
        wb(1'b1, tss_pkg::ADR_IRQS, 8'h03);
        chk({7'h0, irq}, 8'h00);
        wb(1'b1, tss_pkg::ADR_IRQM, 8'h00);
        wb(1'b1, tss_pkg::ADR_STAT, 8'h08);
        u_tss_bus_master.send(~dat, ack);
        chk({7'h0, ack}, 8'h01);
        chk({7'h0, irq}, 8'h00);
        u_tss_bus_master.stop_cond();
        rchk(tss_pkg::ADR_STAT, 8'h00, 8'h20);
        rchk(tss_pkg::ADR_DATA, ~dat, 8'hff);
        rchk(tss_pkg::ADR_IRQS, 8'h05, 8'h05);
        wb(1'b1, tss_pkg::ADR_IRQM, 8'h07);
        chk({7'h0, irq}, 8'h01);
        wb(1'b1, tss_pkg::ADR_IRQS, 8'h07);
        chk({7'h0, irq}, 8'h00);
        dat = 8'($urandom);
        wb(1'b1, tss_pkg::ADR_DATA, dat);
        wb(1'b1, tss_pkg::ADR_STAT, 8'h10);
        u_tss_bus_master.start_cond();
        u_tss_bus_master.send({sadr[7:1], 1'b1}, ack);
        chk({7'h0, ack}, 8'h00);
        rchk(tss_pkg::ADR_STAT, 8'h04, 8'h04);
        u_tss_bus_master.recv(1'b1, got);
        u_tss_bus_master.stop_cond();
        chk(got, dat);
        wb(1'b1, tss_pkg::ADR_STAT, 8'h00);
        // every mode, then two-wire mode with the enable off
        for (int m = 0; m < 9; m++) begin
            dat = (m < 8) ? {m[2:0], 5'h02} : 8'hc0;
            wb(1'b1, tss_pkg::ADR_MODE, dat);
            u_tss_bus_master.start_cond();
            u_tss_bus_master.send({sadr[7:1] ^ 7'(m / 8), 1'b0}, ack);
            u_tss_bus_master.stop_cond();
            chk({7'h0, ack}, {7'h0, m != 6});
        end
        wb(1'b1, tss_pkg::ADR_MODE, 8'hc2);
        rchk(tss_pkg::ADR_STAT, en_stat(8'h00), 8'hff);
        u_tss_bus_master.start_cond();
        u_tss_bus_master.send({~sadr[7], sadr[6:1], 1'b0}, ack);
        u_tss_bus_master.stop_cond();
        chk({7'h0, ack}, 8'h01);
        chk({7'h0, bad}, 8'h00);
        stop_test();
    end
endmodule

// file: verilog/tss_slave.sv
// two-wire serial slave with wishbone register access
// assumes the bus clock is far slower than clock; pins open drain, pulled up outside
`timescale 1ns/1ps
// Overview of operation
// - three-bit mode field; 110 selects two-wire slave, 111 disables.
// - debounce field: 00 none, 01 two cycles, 1x four cycles.
// - debounce only acts in two-wire slave mode.
// - enable off releases lines and idles logic; on activates.
// - enable rise keeps transmit and ack bits, resets the status flags.
// - own address in bits 7..1; bit 0 ignored for matching.
// - device selected only when received address equals own address.
// - one shared data register for sent and received bytes.
// - address register shares its location with spi control two.
// - device is slave only; never makes clock or start.
// - lines driven open drain: pull low or release.
// - mode register bit 4 reads zero.
// - busy set on start, cleared on stop.
// - first seven bits address msb first, eighth bit direction.
// - finished data byte sets done flag and raises interrupt.
// - ack-to-send driven onto data on the ninth clock of each received data byte.
module tss_slave (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic irq
);
    tss_pkg::tss_mode_t mode_q;
    tss_pkg::tss_stat_t stat_q;
    tss_pkg::tss_state_t state_q;
    logic [7:0] sadr_q, data_q, tout_q, shift_q;
    logic [2:0] irqs_q, irqm_q, ev;
    logic [3:0] bit_q;
    logic [2:0] deb_q, sda_deb_q;
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_f_q, sda_f_q, scl_p_q, sda_p_q, en_p_q, ack_q, drv_q;
    logic active, en_rise, scl_rise, scl_fall, start_c, stop_c;
    logic wr, rd_hit, data_rd, data_wr, addr_ok;
    logic [2:0] deb_len;

    assign active = mode_q.interface_enable && mode_q.mode_select == tss_pkg::MODE_TWI;
    assign en_rise = active && !en_p_q;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    assign data_rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == tss_pkg::ADR_DATA;
    assign data_wr = wr && wb_adr_i == tss_pkg::ADR_DATA;
    assign addr_ok = shift_q[7:1] == sadr_q[7:1];

    // sync both lines before anything looks at them
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_i};
            sda_s_q <= {sda_s_q[0], sda_i};
        end
    end

    always_comb begin
        unique case (mode_q.debounce_select)
            tss_pkg::DEB_NONE: deb_len = 3'h0;
            tss_pkg::DEB_TWO: deb_len = tss_pkg::DEB_CNT2;
            default: deb_len = tss_pkg::DEB_CNT4;
        endcase
        if (mode_q.mode_select != tss_pkg::MODE_TWI) begin
            deb_len = 3'h0;
        end
    end

    // clock filter: a new level must persist deb_len + 1 cycles
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scl_f_q <= 1'b1;
            deb_q <= 3'h0;
        end else if (scl_s_q[1] == scl_f_q) begin
            deb_q <= 3'h0;
        end else if (deb_q >= deb_len) begin
            scl_f_q <= scl_s_q[1];
            deb_q <= 3'h0;
        end else begin
            deb_q <= deb_q + 3'h1;
        end
    end

    // data line delayed alike, so start and stop keep their place against the clock
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sda_f_q <= 1'b1;
            sda_deb_q <= 3'h0;
        end else if (sda_s_q[1] == sda_f_q) begin
            sda_deb_q <= 3'h0;
        end else if (sda_deb_q >= deb_len) begin
            sda_f_q <= sda_s_q[1];
            sda_deb_q <= 3'h0;
        end else begin
            sda_deb_q <= sda_deb_q + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            en_p_q <= 1'b0;
        end else begin
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
            en_p_q <= active;
        end
    end

    assign scl_rise = scl_f_q && !scl_p_q;
    assign scl_fall = !scl_f_q && scl_p_q;
    assign start_c = active && scl_f_q && scl_p_q && sda_p_q && !sda_f_q;
    assign stop_c = active && scl_f_q && scl_p_q && !sda_p_q && sda_f_q;

    // byte engine; ack_q marks the ninth bit slot
    always_ff @(posedge clock) begin
        if (!rst_b || !active) begin
            state_q <= tss_pkg::ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ack_q <= 1'b0;
            drv_q <= 1'b0;
        end else if (start_c) begin
            state_q <= tss_pkg::ST_ADDR;
            bit_q <= 4'h0;
            drv_q <= 1'b0;
        end else if (stop_c) begin
            state_q <= tss_pkg::ST_IDLE;
            drv_q <= 1'b0;
        end else begin
            unique case (state_q)
                tss_pkg::ST_IDLE, tss_pkg::ST_SKIP: begin
                    drv_q <= 1'b0;
                end
                tss_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_f_q};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == tss_pkg::BITS_BYTE) begin
                        bit_q <= 4'h0;
                        if (shift_q[7:1] == sadr_q[7:1]) begin
                            state_q <= tss_pkg::ST_ACK;
                            ack_q <= 1'b1;
                            drv_q <= 1'b1;
                        end else begin
                            state_q <= tss_pkg::ST_SKIP;
                        end
                    end
                end
                tss_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        state_q <= tss_pkg::ST_DATA;
                        ack_q <= 1'b0;
                        shift_q <= data_q;
                        drv_q <= stat_q.transmit_select && !data_q[7];
                    end
                end
                tss_pkg::ST_DATA: begin
                    if (scl_rise && !ack_q) begin
                        shift_q <= {shift_q[6:0], sda_f_q};
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall) begin
                        if (ack_q) begin
                            ack_q <= 1'b0;
                            shift_q <= data_q;
                            drv_q <= stat_q.transmit_select && !data_q[7]
                                && !stat_q.ack_received_flag;
                        end else if (bit_q == tss_pkg::BITS_BYTE) begin
                            bit_q <= 4'h0;
                            ack_q <= 1'b1;
                            drv_q <= !stat_q.transmit_select
                                && !stat_q.ack_to_send;
                        end else begin
                            drv_q <= stat_q.transmit_select && !shift_q[7];
                        end
                    end
                end
                default: state_q <= tss_pkg::ST_IDLE;
            endcase
        end
    end

    wire byte_end = state_q == tss_pkg::ST_DATA && scl_fall && !ack_q
        && bit_q == tss_pkg::BITS_BYTE;
    wire addr_end = state_q == tss_pkg::ST_ADDR && scl_fall && bit_q == tss_pkg::BITS_BYTE;
    wire ack_smp = state_q == tss_pkg::ST_DATA && ack_q && scl_rise;

    assign ev[tss_pkg::IRQ_DONE] = byte_end;
    assign ev[tss_pkg::IRQ_MATCH] = addr_end && addr_ok;
    assign ev[tss_pkg::IRQ_STOP] = stop_c;

    // received byte lands in the shared register
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            data_q <= 8'h00;
        end else if (byte_end && !stat_q.transmit_select) begin
            data_q <= shift_q;
        end else if (data_wr) begin
            data_q <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stat_q <= tss_pkg::STAT_RST;
        end else begin
            if (wr && wb_adr_i == tss_pkg::ADR_STAT) begin
                stat_q.transmit_select <= wb_dat_i[4];
                stat_q.ack_to_send <= wb_dat_i[3];
                stat_q.match_wakeup_enable <= wb_dat_i[1];
            end
            if (data_rd || data_wr) begin
                stat_q.transfer_done_flag <= 1'b0;
            end
            if (en_rise) begin
                stat_q.transfer_done_flag <= 1'b1;
                stat_q.address_match_flag <= 1'b0;
                stat_q.bus_busy_flag <= 1'b0;
                stat_q.master_read_flag <= 1'b0;
                stat_q.ack_received_flag <= 1'b1;
            end
            if (start_c) begin
                stat_q.bus_busy_flag <= 1'b1;
                stat_q.transfer_done_flag <= 1'b0;
                stat_q.address_match_flag <= 1'b0;
            end
            if (stop_c) begin
                stat_q.bus_busy_flag <= 1'b0;
                stat_q.transfer_done_flag <= 1'b1;
            end
            if (addr_end) begin
                stat_q.address_match_flag <= addr_ok;
                stat_q.master_read_flag <= shift_q[0];
            end
            if (byte_end) begin
                stat_q.transfer_done_flag <= 1'b1;
            end
            if (ack_smp) begin
                stat_q.ack_received_flag <= sda_f_q;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mode_q <= {tss_pkg::MODE_RST[7:5], tss_pkg::MODE_RST[3:0]};
            sadr_q <= 8'h00;
            tout_q <= 8'h00;
            irqm_q <= 3'h0;
        end else if (wr) begin
            unique case (wb_adr_i)
                tss_pkg::ADR_MODE: mode_q <= {wb_dat_i[7:5], wb_dat_i[3:0]};
                tss_pkg::ADR_SADR: sadr_q <= wb_dat_i[7:0];
                tss_pkg::ADR_TOUT: tout_q <= wb_dat_i[7:0];
                tss_pkg::ADR_IRQM: irqm_q <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // sticky events, write one clears, set wins
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            irqs_q <= 3'h0;
        end else if (wr && wb_adr_i == tss_pkg::ADR_IRQS) begin
            irqs_q <= (irqs_q & ~wb_dat_i[2:0]) | ev;
        end else begin
            irqs_q <= irqs_q | ev;
        end
    end

    assign irq = |(irqs_q & irqm_q);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            unique case (wb_adr_i)
                tss_pkg::ADR_MODE: wb_dat_o <= {24'h0, mode_q[6:4], 1'b0, mode_q[3:0]};
                tss_pkg::ADR_STAT: wb_dat_o <= {24'h0, stat_q};
                tss_pkg::ADR_SADR: wb_dat_o <= {24'h0, sadr_q};
                tss_pkg::ADR_DATA: wb_dat_o <= {24'h0, data_q};
                tss_pkg::ADR_TOUT: wb_dat_o <= {24'h0, tout_q};
                tss_pkg::ADR_IRQS: wb_dat_o <= {29'h0, irqs_q};
                tss_pkg::ADR_IRQM: wb_dat_o <= {29'h0, irqm_q};
                default: wb_dat_o <= 32'h0;
            endcase
        end
    end

    assign scl_o = 1'b0;
    assign scl_oe = 1'b0;
    assign sda_o = 1'b0;
    assign sda_oe = active && drv_q;

    a_busy_start: assert property (@(posedge clock) disable iff (!rst_b)
        start_c |=> stat_q.bus_busy_flag) else $error("busy not set on start");
    a_busy_stop: assert property (@(posedge clock) disable iff (!rst_b)
        stop_c && !start_c |=> !stat_q.bus_busy_flag) else $error("busy not cleared");
    a_done_byte: assert property (@(posedge clock) disable iff (!rst_b)
        byte_end |=> stat_q.transfer_done_flag && irqs_q[0]) else $error("done missing");
    a_idle_off: assert property (@(posedge clock) disable iff (!rst_b)
        !active |=> !sda_oe) else $error("driving while off");
    a_enable_flags: assert property (@(posedge clock) disable iff (!rst_b)
        en_rise && !start_c |=> !stat_q.bus_busy_flag && stat_q.ack_received_flag)
        else $error("flags not reset on enable");
    a_match_addr: assert property (@(posedge clock) disable iff (!rst_b)
        addr_end |=> stat_q.address_match_flag == $past(addr_ok)) else $error("match wrong");
    a_mode_bit4: assert property (@(posedge clock) disable iff (!rst_b)
        wb_ack_o && $past(wb_adr_i) == tss_pkg::ADR_MODE |-> !wb_dat_o[4])
        else $error("bit 4 nonzero");
    a_scl_never: assert property (@(posedge clock) disable iff (!rst_b)
        !scl_oe && !sda_o) else $error("line driven high");
    a_ack_send: assert property (@(posedge clock) disable iff (!rst_b)
        byte_end && !stat_q.transmit_select |=> !active
        || sda_oe == !$past(stat_q.ack_to_send)) else $error("ack bit not driven");
    a_stop_done: assert property (@(posedge clock) disable iff (!rst_b)
        stop_c |=> stat_q.transfer_done_flag && irqs_q[tss_pkg::IRQ_STOP])
        else $error("stop not flagged");
    c_start: cover property (@(posedge clock) start_c);
    c_match: cover property (@(posedge clock) ev[1]);
    c_byte: cover property (@(posedge clock) byte_end);
    c_stop: cover property (@(posedge clock) stop_c);
endmodule
